// File: common/ipl_defs.svh
// constants for the interrupt priority level bank
//
// Notes on behaviour
// (RQ1) Field code 01 gives level 0, 10 gives level 1, 11 gives level 2.
// (RQ2) Field code 00 disables the source; every field resets to 00.
// (RQ3) No encoding places any source above level 2.
// (RQ4) Bits 11-10 of the serial/timer A register read zero, writes ignored.
// (RQ5) Serial receive full at bits 15-14, receive error at 13-12.
// (RQ6) Serial transmit idle at bits 9-8, transmit empty at 7-6.
// (RQ7) Timer A channels 3, 2, 1 at bits 5-4, 3-2, 1-0.
// (RQ8) Timer A ch0, timer B ch3, ch2 at bits 15-14, 13-12, 11-10.
// (RQ9) Timer B ch1, ch0, timer C ch3 at bits 9-8, 7-6, 5-4.
// (RQ10) Timer C channels 2 and 1 at bits 3-2 and 1-0.
// (RQ11) PWM A fault at bits 15-14, PWM B fault at 13-12.
// (RQ12) PWM A reload at bits 11-10, PWM B reload at 9-8.
// (RQ13) ADC A zero cross 7-6, ADC B zero cross 5-4, ADC A done 3-2.
// (RQ14) ADC B conversion complete at bits 1-0, same encoding.
// (RQ15) Registered enable and level per source, updated on the write-completing edge.
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

// ==========================================================
// register indices, byte address is four times the index
`define TIMER_ABC_IDX         10'h007
`define SERIAL0_TIMER_A_IDX   10'h008
`define PWM_ADC_IDX           10'h009

// ==========================================================
// reset values and writable masks
`define TIMER_ABC_RST         16'h0000
`define SERIAL0_TIMER_A_RST   16'h0000
`define PWM_ADC_RST           16'h0000
`define TIMER_ABC_WMASK       16'hFFFF
`define SERIAL0_TIMER_A_WMASK 16'hF3FF
`define PWM_ADC_WMASK         16'hFFFF

// ==========================================================
// field positions (lsb of each 2-bit field)
`define POS_TMR_A_CH0   14
`define POS_TMR_B_CH3   12
`define POS_TMR_B_CH2   10
`define POS_TMR_B_CH1   8
`define POS_TMR_B_CH0   6
`define POS_TMR_C_CH3   4
`define POS_TMR_C_CH2   2
`define POS_TMR_C_CH1   0
`define POS_SER_RX_FULL 14
`define POS_SER_RX_ERR  12
`define POS_SER_TX_IDLE 8
`define POS_SER_TX_EMPT 6
`define POS_TMR_A_CH3   4
`define POS_TMR_A_CH2   2
`define POS_TMR_A_CH1   0
`define POS_PWM_A_FLT   14
`define POS_PWM_B_FLT   12
`define POS_PWM_A_RL    10
`define POS_PWM_B_RL    8
`define POS_ADC_A_ZC    6
`define POS_ADC_B_ZC    4
`define POS_ADC_A_CC    2
`define POS_ADC_B_CC    0

// ==========================================================
// field codes
`define CODE_DISABLED   2'b00

`endif

// File: common/ipl_pkg.sv
// types shared by the interrupt priority level bank
package ipl_pkg;

  // ==========================================================
  // basic types
  typedef logic [9:0]  idx_t;
  typedef logic [15:0] reg16_t;
  typedef logic [1:0]  code_t;

  // ==========================================================
  // source numbering on the enable and level vectors
  typedef enum {
    adc_b_conv_done_src, adc_a_conv_done_src, adc_b_zero_cross_src, adc_a_zero_cross_src,
    pwm_b_reload_src, pwm_a_reload_src, pwm_b_fault_src, pwm_a_fault_src,
    timer_a_ch1_src, timer_a_ch2_src, timer_a_ch3_src,
    serial0_transmit_empty_src, serial0_transmit_idle_src,
    serial0_receive_error_src, serial0_receive_full_src,
    timer_c_ch1_src, timer_c_ch2_src, timer_c_ch3_src,
    timer_b_ch0_src, timer_b_ch1_src, timer_b_ch2_src, timer_b_ch3_src,
    timer_a_ch0_src, num_src
  } src_e;

  // ==========================================================
  // bus front state
  typedef enum {ph_idle, ph_write} phase_e;

  typedef struct packed {
    phase_e phase;
    idx_t   idx;
  } front_s;

endpackage : ipl_pkg

// File: common/reg_access_if.sv
// register access strobes from the bus front to the register bank
`timescale 1ns/1ps
interface reg_access_if;
  import ipl_pkg::*;
  logic rd_req;
  idx_t rd_idx;
  logic wr_req;
  idx_t wr_idx;

  modport front (output rd_req, rd_idx, wr_req, wr_idx);
  modport bank  (input  rd_req, rd_idx, wr_req, wr_idx);
endinterface : reg_access_if

// File: hw/ahb_front.sv
// ahb-lite slave front end: address phase capture and access strobes
`timescale 1ns/1ps
module ahb_front (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite address phase
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  // strobes to the bank
  reg_access_if.front      acc
);
  import ipl_pkg::*;

  front_s state_reg;
  front_s state_next;
  logic   take;

  // ==========================================================
  // address phase taken on nonseq or seq while the bus is ready
  assign take       = hsel && hready && htrans[1];
  assign acc.rd_req = take && !hwrite;
  assign acc.rd_idx = haddr[11:2];
  assign acc.wr_req = (state_reg.phase == ph_write);
  assign acc.wr_idx = state_reg.idx;

  // next state: remember a write for its data phase
  always_comb begin
    state_next = state_reg;
    case (state_reg.phase)
      ph_idle,
      ph_write: begin
        if (take && hwrite) begin
          state_next.phase = ph_write;
          state_next.idx   = haddr[11:2];
        end else begin
          state_next.phase = ph_idle;
        end
      end
      default: state_next.phase = ph_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '{phase: ph_idle, idx: '0};
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ahb_front

// File: hw/level_decode.sv
// per-source decode of priority codes into registered enable and level
`timescale 1ns/1ps
module level_decode #(
  parameter int NUM_SRC = 23
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // field codes as they will stand after this edge
  input  wire logic [2*NUM_SRC-1:0] code_next,
  // decoded outputs
  output logic      [NUM_SRC-1:0]   src_enable,
  output logic      [2*NUM_SRC-1:0] src_level
);
  import ipl_pkg::*;
  `include "ipl_defs.svh"

  typedef struct packed {
    logic [NUM_SRC-1:0]   en;
    logic [2*NUM_SRC-1:0] lvl;
  } dec_s;

  dec_s state_reg;
  dec_s state_next;

  // code minus one; 00 leaves level 0 but the enable is low
  function automatic code_t code_to_level(input code_t c);
    code_to_level = (c == `CODE_DISABLED) ? 2'h0 : code_t'(c - 2'h1); // see (RQ1) see (RQ3)
  endfunction : code_to_level

  // ==========================================================
  // decode from the next field value so outputs move with the write edge
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NUM_SRC; i++) begin
      state_next.en[i]       = (code_next[2*i +: 2] != `CODE_DISABLED); // see (RQ2)
      state_next.lvl[2*i +: 2] = code_to_level(code_next[2*i +: 2]);  // see (RQ15)
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign src_enable = state_reg.en;
  assign src_level  = state_reg.lvl;
endmodule : level_decode

// File: hw/ipl_bank.sv
// interrupt priority level bank: three priority registers on ahb-lite
`timescale 1ns/1ps
module ipl_bank (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // per-source outputs to the arbiter, indexed by ipl_pkg::src_e
  output logic      [22:0] src_enable,
  output logic      [45:0] src_level
);
  import ipl_pkg::*;
  `include "ipl_defs.svh"

  localparam int NSRC = int'(num_src);

  typedef struct packed {
    reg16_t timer_abc_priority;
    reg16_t serial0_timer_a_priority;
    reg16_t pwm_adc_priority;
    reg16_t rdata;
  } bank_s;

  bank_s              state_reg;
  bank_s              state_next;
  logic [2*NSRC-1:0]  code_next;
  reg_access_if       acc ();

  // ==========================================================
  // bus front
  ahb_front u_front (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .acc     (acc)
  );

  // ==========================================================
  // read mux, unmapped indices read zero
  function automatic reg16_t read_mux(input idx_t idx, input bank_s s);
    case (idx)
      `TIMER_ABC_IDX:       read_mux = s.timer_abc_priority;
      `SERIAL0_TIMER_A_IDX: read_mux = s.serial0_timer_a_priority & `SERIAL0_TIMER_A_WMASK; // see (RQ4)
      `PWM_ADC_IDX:         read_mux = s.pwm_adc_priority;
      default:              read_mux = 16'h0000;
    endcase
  endfunction : read_mux

  // ==========================================================
  // register updates and read data capture
  // the read uses next values so a read right behind a write sees it
  always_comb begin
    state_next = state_reg;
    if (acc.wr_req) begin
      case (acc.wr_idx)
        `TIMER_ABC_IDX:       state_next.timer_abc_priority = hwdata[15:0] & `TIMER_ABC_WMASK; // see (RQ15)
        `SERIAL0_TIMER_A_IDX: state_next.serial0_timer_a_priority =
                                hwdata[15:0] & `SERIAL0_TIMER_A_WMASK;                        // see (RQ4)
        `PWM_ADC_IDX:         state_next.pwm_adc_priority = hwdata[15:0] & `PWM_ADC_WMASK;
        default:              state_next.rdata = state_reg.rdata; // unmapped write is dropped
      endcase
    end
    if (acc.rd_req) begin
      state_next.rdata = read_mux(acc.rd_idx, state_next);
    end
  end

  // every field starts disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '{timer_abc_priority:       `TIMER_ABC_RST,       // see (RQ2)
                     serial0_timer_a_priority: `SERIAL0_TIMER_A_RST,
                     pwm_adc_priority:         `PWM_ADC_RST,
                     rdata:                    16'h0000};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // gather field codes by source number
  always_comb begin
    code_next = '0;
    code_next[2*timer_a_ch0_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_A_CH0 +: 2]; // see (RQ8)
    code_next[2*timer_b_ch3_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_B_CH3 +: 2]; // see (RQ8)
    code_next[2*timer_b_ch2_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_B_CH2 +: 2]; // see (RQ8)
    code_next[2*timer_b_ch1_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_B_CH1 +: 2]; // see (RQ9)
    code_next[2*timer_b_ch0_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_B_CH0 +: 2]; // see (RQ9)
    code_next[2*timer_c_ch3_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_C_CH3 +: 2]; // see (RQ9)
    code_next[2*timer_c_ch2_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_C_CH2 +: 2]; // see (RQ10)
    code_next[2*timer_c_ch1_src +: 2]  = state_next.timer_abc_priority[`POS_TMR_C_CH1 +: 2]; // see (RQ10)
    code_next[2*serial0_receive_full_src +: 2] =
      state_next.serial0_timer_a_priority[`POS_SER_RX_FULL +: 2];                             // see (RQ5)
    code_next[2*serial0_receive_error_src +: 2] =
      state_next.serial0_timer_a_priority[`POS_SER_RX_ERR +: 2];                              // see (RQ5)
    code_next[2*serial0_transmit_idle_src +: 2] =
      state_next.serial0_timer_a_priority[`POS_SER_TX_IDLE +: 2];                             // see (RQ6)
    code_next[2*serial0_transmit_empty_src +: 2] =
      state_next.serial0_timer_a_priority[`POS_SER_TX_EMPT +: 2];                             // see (RQ6)
    code_next[2*timer_a_ch3_src +: 2]  = state_next.serial0_timer_a_priority[`POS_TMR_A_CH3 +: 2]; // see (RQ7)
    code_next[2*timer_a_ch2_src +: 2]  = state_next.serial0_timer_a_priority[`POS_TMR_A_CH2 +: 2]; // see (RQ7)
    code_next[2*timer_a_ch1_src +: 2]  = state_next.serial0_timer_a_priority[`POS_TMR_A_CH1 +: 2]; // see (RQ7)
    code_next[2*pwm_a_fault_src +: 2]  = state_next.pwm_adc_priority[`POS_PWM_A_FLT +: 2]; // see (RQ11)
    code_next[2*pwm_b_fault_src +: 2]  = state_next.pwm_adc_priority[`POS_PWM_B_FLT +: 2]; // see (RQ11)
    code_next[2*pwm_a_reload_src +: 2] = state_next.pwm_adc_priority[`POS_PWM_A_RL +: 2];  // see (RQ12)
    code_next[2*pwm_b_reload_src +: 2] = state_next.pwm_adc_priority[`POS_PWM_B_RL +: 2];  // see (RQ12)
    code_next[2*adc_a_zero_cross_src +: 2] = state_next.pwm_adc_priority[`POS_ADC_A_ZC +: 2]; // see (RQ13)
    code_next[2*adc_b_zero_cross_src +: 2] = state_next.pwm_adc_priority[`POS_ADC_B_ZC +: 2]; // see (RQ13)
    code_next[2*adc_a_conv_done_src +: 2]  = state_next.pwm_adc_priority[`POS_ADC_A_CC +: 2]; // see (RQ13)
    code_next[2*adc_b_conv_done_src +: 2]  = state_next.pwm_adc_priority[`POS_ADC_B_CC +: 2]; // see (RQ14)
  end

  // ==========================================================
  // decode into registered enables and levels
  level_decode #(
    .NUM_SRC (NSRC)
  ) u_decode (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .code_next  (code_next),
    .src_enable (src_enable),
    .src_level  (src_level)
  );

  // ==========================================================
  // bus answers: zero wait states, always okay; hsize unused, word access only
  assign hrdata    = {16'h0000, state_reg.rdata};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : ipl_bank

// File: test/arb_model.sv
// far-side arbiter model: highest requested level
`timescale 1ns/1ps
module arb_model (
  // from the bank
  input  wire logic [22:0] src_enable,
  input  wire logic [45:0] src_level,
  // summary
  output logic             any_req,
  output logic [1:0]       top_level
);
  // ======
  // scan every source; a level above 2 would win here
  always_comb begin
    any_req   = |src_enable;
    top_level = 2'h0;
    for (int i = 0; i < 23; i++) begin
      if (src_enable[i] && src_level[2*i+:2] > top_level) begin
        top_level = src_level[2*i+:2];
      end
    end
  end
endmodule : arb_model

// File: test/ipl_bank_props_props.sv
// port checker for the priority level bank
`timescale 1ns/1ps
module ipl_bank_props (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // arbiter side
  input wire logic [22:0] src_enable,
  input wire logic [45:0] src_level
);
  logic        wr_ph;
  logic        rd_ph;
  logic [9:0]  ph_ix;
  logic [7:0]  en_w;
  logic [15:0] lv_w;
  logic [45:0] en_x;
  logic        lv3;
  // ======
  // expected decode of write data, and spread enables
  always_comb begin
    lv3 = 1'b0;
    for (int k = 0; k < 8; k++) begin
      en_w[k] = |hwdata[2*k+:2];
      lv_w[2*k+:2] = en_w[k] ? hwdata[2*k+:2] - 2'h1 : 2'h0;
    end
    for (int i = 0; i < 23; i++) begin
      en_x[2*i+:2] = {2{src_enable[i]}};
      lv3 = lv3 | (&src_level[2*i+:2]);
    end
  end
  // data phase tracking, only moves when the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      ph_ix <= 10'h000;
    end else if (hready) begin
      wr_ph <= hsel && htrans[1] && hwrite;
      rd_ph <= hsel && htrans[1] && !hwrite;
      ph_ix <= haddr[11:2];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ======
  // assertions
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rsv; rd_ph && ph_ix == 10'h008 |-> hrdata[11:10] == 2'h0 && hrdata[31:16] == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_ser; wr_ph && ph_ix == 10'h008 |=> src_enable[14:11] == $past({en_w[7:6], en_w[4:3]})
    && src_level[29:22] == $past({lv_w[15:12], lv_w[9:6]}); endproperty
  a_ser: assert property (p_ser) else $error("serial field decode wrong");
  property p_tma; wr_ph && ph_ix == 10'h008 |=> src_enable[10:8] == $past(en_w[2:0])
    && src_level[21:16] == $past(lv_w[5:0]); endproperty
  a_tma: assert property (p_tma) else $error("timer a field decode wrong");
  property p_abc; wr_ph && ph_ix == 10'h007 |=> src_enable[22:15] == $past(en_w)
    && src_level[45:30] == $past(lv_w); endproperty
  a_abc: assert property (p_abc) else $error("timer field decode wrong");
  property p_pa; wr_ph && ph_ix == 10'h009 |=> src_enable[7:0] == $past(en_w)
    && src_level[15:0] == $past(lv_w); endproperty
  a_pa: assert property (p_pa) else $error("pwm adc field decode wrong");
  property p_cap; (src_level & ~en_x) == 46'h0 && !lv3; endproperty
  a_cap: assert property (p_cap) else $error("level out of range");
  property p_hold; !wr_ph |=> $stable(src_enable) && $stable(src_level); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without write");
  property p_rst; $rose(hresetn) |-> src_enable == 23'h0 && src_level == 46'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule : ipl_bank_props

// File: test/tb_top.sv
// self-checking bench for the priority level bank
`timescale 1ns/1ps
module tb_top;
  import ipl_pkg::*;
  typedef struct packed {
    idx_t   ix;
    reg16_t wd;
    reg16_t rd;
  } row_s;
  // ======
  // ordinary cases: index, write data, expected read
  localparam row_s ROWS [6] = '{'{10'h007, 16'hFFFF, 16'hFFFF}, '{10'h008, 16'hFFFF, 16'hF3FF},
    '{10'h009, 16'hA5C3, 16'hA5C3}, '{10'h003, 16'hFFFF, 16'h0000},
    '{10'h008, 16'h0C00, 16'h0000}, '{10'h007, 16'h1234, 16'h1234}};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, any_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, top_level;
  logic [2:0]  hsize;
  logic [22:0] src_enable;
  logic [45:0] src_level;
  int          miscompares, cmp_count;
  ipl_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_enable(src_enable), .src_level(src_level));
  arb_model u_arb (.src_enable(src_enable), .src_level(src_level), .any_req(any_req), .top_level(top_level));
  // clock
  always #10 hclk = ~hclk;
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // single word transfer; waits are bounded so a stuck slave ends the run
  task automatic bus(input logic w, input idx_t ix, input reg16_t d, output logic [31:0] r);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {20'h00000, ix, 2'b00};
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
        miscompares++;
        $display("unexpected at %0t: bus hang", $time);
        end_of_test();
      end
      if (p == 0) begin
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
      end
    end
    r = hrdata;
  endtask : bus
  // ======
  // main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 7; i < 10; i++) begin
      bus(1'b0, i[9:0], 16'h0000, rd);
      chk(rd, 32'h0, "reset value");
    end
    $display("reset values done");
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].ix, ROWS[i].wd, rd);
      bus(1'b0, ROWS[i].ix, 16'h0000, rd);
      chk(rd, {16'h0000, ROWS[i].rd}, "read back");
    end
    $display("table rows done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 10'h007, 16'h0000, rd);
    chk(rd, 32'h0, "mid-run reset read");
    chk({31'h0, any_req}, 32'h0, "mid-run reset request");
    $display("mid-run reset done");
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, 10'h009, 16'(c), rd);
      @(posedge hclk);
      chk({29'h0, any_req, top_level}, {29'h0, 1'b1, 2'(c - 1)}, "level code");
    end
    bus(1'b1, 10'h009, 16'h0000, rd);
    bus(1'b1, 10'h008, 16'h0C00, rd);
    @(posedge hclk);
    chk({29'h0, any_req, top_level}, 32'h0, "disabled");
    $display("arbiter codes done");
    end_of_test();
  end
endmodule : tb_top
bind ipl_bank ipl_bank_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .src_enable(src_enable), .src_level(src_level));
